//--- rtl/ett_exposure_trigger.sv
// Purpose: Exposure trigger timing for a flat-panel X-ray detector
// Assumes: Single 40 MHz clock, synchronous inputs, millisecond timers
// Notes:   Filters may run up to one tick long, never short
`timescale 1ns/10ps
`include "ett_defines.svh"
// Function
// - In auto mode a filtered sensor indication starts acquisition alone.
// - In wired mode the filtered request is handshaken before acquisition.
// - The integration window stays open for the programmed time, default 500 ms.
// - After the grant rises the pre-integration wait runs, default 0 ms.
// - A valid request waits the grant delay, default 1 ms, before grant.
// - Wired mode takes request changes only after the wired filter time.
// - Auto mode takes the sensor only after the sensor filter time.
// - A sensor pulse shorter than its filter time never triggers.
// - Sensor filter time is set in 1 ms steps, advised at most 10 ms.
// - Six sensitivity settings 0 to 5 each select a distinct gain.
module ett_exposure_trigger
  import ett_pkg::*;
#(
  parameter int TICK_CYCLES = `ETT_TICK_CYCLES,
  parameter int TIME_W      = 16,
  parameter int FILT_W      = 8
) (
  input  wire logic                CLOCK,
  input  wire logic                RST,
  input  wire logic                CE,
  input  wire ett_pkg::ett_mode_t  MODE,
  input  wire logic                EXPOSURE_REQUEST,
  input  wire logic                XRAY_SENSE,
  input  wire logic [TIME_W-1:0]   WINDOW_MS,
  input  wire logic [TIME_W-1:0]   PRE_MS,
  input  wire logic [TIME_W-1:0]   GRANT_DELAY_MS,
  input  wire logic [FILT_W-1:0]   WIRED_FILTER_MS,
  input  wire logic [FILT_W-1:0]   SENSOR_FILTER_MS,
  input  wire logic [2:0]          GAIN_SELECT,
  output logic                     EXPOSURE_GRANT,
  output logic                     INTEGRATING,
  output logic                     FRAME_DONE,
  output logic [2:0]               GAIN_ACTIVE,
  output logic                     GAIN_INVALID,
  output ett_pkg::ett_state_t      STATE
);
  import ett_pkg::*;

  if (TICK_CYCLES < 2 || TIME_W < 2 || FILT_W < 2) begin
    $error("ett_exposure_trigger: parameter out of range");
  end

  localparam int TW = $clog2(TICK_CYCLES);

  logic [TW-1:0]     tick_count;
  logic [TW-1:0]     next_tick_count;
  logic              tick;
  logic              req_ok;
  logic              sense_ok;
  logic              wired_en;
  logic              auto_en;
  ett_state_t        state;
  ett_state_t        next_state;
  logic [TIME_W-1:0] ms;
  logic [TIME_W-1:0] next_ms;
  logic              next_grant;
  logic              next_done;
  logic [2:0]        next_gain;

  function automatic logic elapsed(input logic [TIME_W-1:0] cnt,
                                   input logic [TIME_W-1:0] lim);
    elapsed = (cnt >= lim);
  endfunction

  // Millisecond tick from the system clock
  always_comb begin
    tick            = (tick_count == TW'(TICK_CYCLES - 1));
    next_tick_count = tick ? '0 : tick_count + 1'b1;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tick_count <= '0;
    end else if (CE) begin
      tick_count <= next_tick_count;
    end
  end

  assign wired_en = (MODE == ETT_MODE_WIRED);
  assign auto_en  = (MODE == ETT_MODE_AUTO);

  // Each filter only runs in its own mode; the other is held clear
  ett_filter #(.WIDTH(FILT_W)) u_wired_filter (
    .clk      (CLOCK),
    .rst      (RST),
    .ce       (CE),
    .enable   (wired_en),
    .tick     (tick),
    .limit    (WIRED_FILTER_MS),
    .raw      (EXPOSURE_REQUEST),
    .filtered (req_ok)
  );

  ett_filter #(.WIDTH(FILT_W)) u_sensor_filter (
    .clk      (CLOCK),
    .rst      (RST),
    .ce       (CE),
    .enable   (auto_en),
    .tick     (tick),
    .limit    (SENSOR_FILTER_MS),
    .raw      (XRAY_SENSE),
    .filtered (sense_ok)
  );

  // Exposure sequence
  always_comb begin
    next_state = state;
    next_ms    = ms;
    next_grant = EXPOSURE_GRANT;
    next_done  = 1'b0;
    if (tick && ms != '1) begin
      next_ms = ms + 1'b1;
    end
    unique case (state)
      ETT_IDLE: begin
        next_ms    = '0;
        next_grant = 1'b0;
        if (wired_en && req_ok) begin
          next_state = ETT_GRANT_WAIT;
        end else if (auto_en && sense_ok) begin
          next_state = ETT_INTEGRATE;
        end
      end
      ETT_GRANT_WAIT: begin
        if (!req_ok) begin
          next_state = ETT_IDLE;
        end else if (elapsed(ms, GRANT_DELAY_MS)) begin
          next_grant = 1'b1;
          next_ms    = '0;
          next_state = ETT_PRE_WAIT;
        end
      end
      ETT_PRE_WAIT: begin
        if (elapsed(ms, PRE_MS)) begin
          next_ms    = '0;
          next_state = ETT_INTEGRATE;
        end
      end
      ETT_INTEGRATE: begin
        // Window runs until ms reaches the live WINDOW_MS; request drop does not cut it
        if (elapsed(ms, WINDOW_MS)) begin
          next_done  = 1'b1;
          next_grant = 1'b0;
          next_state = ETT_RELEASE;
        end
      end
      ETT_RELEASE: begin
        // Wait for the trigger to fall so one exposure gives one frame
        if (!req_ok && !sense_ok) begin
          next_state = ETT_IDLE;
        end
      end
      default: next_state = ETT_IDLE;
    endcase
  end

  // Gain setting latched only while idle so a frame sees one gain
  always_comb begin
    next_gain = GAIN_ACTIVE;
    if (state == ETT_IDLE && GAIN_SELECT <= `ETT_GAIN_MAX) begin
      next_gain = GAIN_SELECT;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state          <= ETT_IDLE;
      ms             <= '0;
      EXPOSURE_GRANT <= 1'b0;
      FRAME_DONE     <= 1'b0;
      GAIN_ACTIVE    <= `ETT_GAIN_DEF;
    end else if (CE) begin
      state          <= next_state;
      ms             <= next_ms;
      EXPOSURE_GRANT <= next_grant;
      FRAME_DONE     <= next_done;
      GAIN_ACTIVE    <= next_gain;
    end
  end

  assign INTEGRATING  = (state == ETT_INTEGRATE);
  assign GAIN_INVALID = (GAIN_SELECT > `ETT_GAIN_MAX);
  assign STATE        = state;

  a_grant_idle: assert property (@(posedge CLOCK) disable iff (RST)
    (state == ETT_IDLE && $past(state) == ETT_IDLE) |-> !EXPOSURE_GRANT)
    else $error("grant high while idle");

  a_grant_mode: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(EXPOSURE_GRANT) |-> wired_en)
    else $error("grant rose outside wired mode");

  a_grant_pre: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(EXPOSURE_GRANT) |-> state == ETT_PRE_WAIT && ms == '0)
    else $error("grant not followed by pre wait");

  a_auto_start: assert property (@(posedge CLOCK) disable iff (RST)
    (CE && state == ETT_IDLE && auto_en && sense_ok)
      |=> state == ETT_INTEGRATE)
    else $error("auto trigger did not open window");

  a_auto_filter: assert property (@(posedge CLOCK) disable iff (RST)
    $past(CE && wired_en) |-> !sense_ok)
    else $error("sensor filter active in wired mode");

  a_wired_filter: assert property (@(posedge CLOCK) disable iff (RST)
    $past(CE && auto_en) |-> !req_ok)
    else $error("wired filter active in auto mode");

  a_window_end: assert property (@(posedge CLOCK) disable iff (RST)
    (CE && state == ETT_INTEGRATE && ms >= WINDOW_MS)
      |=> FRAME_DONE && state == ETT_RELEASE)
    else $error("window did not close on time");

  a_pre_end: assert property (@(posedge CLOCK) disable iff (RST)
    (CE && state == ETT_PRE_WAIT && ms >= PRE_MS) |=> INTEGRATING)
    else $error("pre wait did not end on time");

  a_gain_range: assert property (@(posedge CLOCK) disable iff (RST)
    GAIN_ACTIVE <= `ETT_GAIN_MAX)
    else $error("gain out of range");

  a_tick_period: assert property (@(posedge CLOCK) disable iff (RST)
    (CE && tick) |=> !tick)
    else $error("tick lasted more than one cycle");
endmodule

//--- rtl/ett_defines.svh
// Purpose: Constants for the exposure trigger timing block
// Assumes: 40 MHz system clock
// Notes:   Times in milliseconds, counts in clock cycles
`ifndef ETT_DEFINES_SVH
`define ETT_DEFINES_SVH
`define ETT_CLK_HZ           40000000
`define ETT_TICK_MS          1
`define ETT_TICK_CYCLES      ((`ETT_CLK_HZ / 1000) * `ETT_TICK_MS)
`define ETT_WINDOW_MS_DEF    16'h01f4
`define ETT_PRE_MS_DEF       16'h0000
`define ETT_GRANT_MS_DEF     16'h0001
`define ETT_WIRED_FILT_DEF   8'h03
`define ETT_SENSOR_FILT_DEF  8'h03
`define ETT_SENSOR_FILT_MAX  8'h0a
`define ETT_GAIN_MAX         3'h5
`define ETT_GAIN_DEF         3'h0
`endif

//--- rtl/ett_pkg.sv
// Purpose: Types for the exposure trigger timing block
// Assumes: Nothing
// Notes:   Mode select and controller states
package ett_pkg;
  typedef enum logic {ETT_MODE_WIRED, ETT_MODE_AUTO} ett_mode_t;
  typedef enum logic [2:0] {
    ETT_IDLE, ETT_GRANT_WAIT, ETT_PRE_WAIT, ETT_INTEGRATE, ETT_RELEASE
  } ett_state_t;
endpackage

//--- rtl/ett_filter.sv
// Purpose: Stability filter counting millisecond ticks
// Assumes: Input synchronous to clock
// Notes:   Output follows input after it held steady for limit + 1 ticks
`timescale 1ns/10ps
`include "ett_defines.svh"
module ett_filter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             enable,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] limit,
  input  wire logic             raw,
  output logic                  filtered
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_filtered;

  if (WIDTH < 1) begin
    $error("ett_filter: width out of range");
  end

  always_comb begin
    next_count    = count;
    next_filtered = filtered;
    if (!enable) begin
      next_count    = '0;
      next_filtered = 1'b0;
    end else if (raw == filtered) begin
      next_count = '0;
    end else if (tick) begin
      // The first tick may come at once, so one extra tick keeps the
      // accepted time at or above the filter time, never below it
      if (count >= limit) begin
        next_filtered = raw;
        next_count    = '0;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count    <= '0;
      filtered <= 1'b0;
    end else if (ce) begin
      count    <= next_count;
      filtered <= next_filtered;
    end
  end
endmodule

//--- verification/ett_xray_generator.sv
// Purpose: Behavioural generator exposure control on the cable
// Assumes: Driven from the detector system clock
// Notes:   Answers one clock late, like a slow relay interface
`timescale 1ns/10ps
module ett_xray_generator (
  input  wire logic clk,
  input  wire logic fire,
  input  wire logic grant,
  output logic      request,
  output logic      xray
);
  initial request = 1'b0;
  initial xray = 1'b0;
  always @(posedge clk) begin
    request <= #2 fire;
    xray    <= #2 fire && request && grant;
  end
endmodule

//--- verification/ett_exposure_trigger_test.sv
// Purpose: Self-checking bench for exposure trigger timing
// Assumes: Tick shortened to 4 clocks
// Notes:   Filters may run long by one tick, so timing uses windows
`timescale 1ns/10ps
module ett_exposure_trigger_test;
  import ett_pkg::*;
  localparam int T = 4;
  logic        clk = 0;
  logic        rst = 1;
  logic        fire = 0;
  logic        sense = 0;
  logic        ce = 1;
  logic        req;
  logic        gx;
  ett_mode_t   mode = ETT_MODE_WIRED;
  logic [15:0] win = 16'h01f4;
  logic [15:0] pre = 16'h0000;
  logic [15:0] gdl = 16'h0001;
  logic [7:0]  wf = 8'h03;
  logic [7:0]  sf = 8'h03;
  logic [2:0]  gsel = 3'h0;
  logic [2:0]  gact;
  logic        grant;
  logic        integ;
  logic        done;
  logic        ginv;
  ett_state_t  st;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;

  ett_exposure_trigger #(.TICK_CYCLES(T)) dut (
    .CLOCK(clk), .RST(rst), .CE(ce), .MODE(mode),
    .EXPOSURE_REQUEST(req),
    .XRAY_SENSE(mode == ETT_MODE_AUTO ? sense : gx),
    .WINDOW_MS(win), .PRE_MS(pre), .GRANT_DELAY_MS(gdl),
    .WIRED_FILTER_MS(wf), .SENSOR_FILTER_MS(sf), .GAIN_SELECT(gsel),
    .EXPOSURE_GRANT(grant), .INTEGRATING(integ), .FRAME_DONE(done),
    .GAIN_ACTIVE(gact), .GAIN_INVALID(ginv), .STATE(st));
  ett_xray_generator gen (.clk(clk), .fire(fire), .grant(grant),
    .request(req), .xray(gx));

  initial forever #12.5 clk = ~clk;
  // Ceiling well above the two full exposures plus short runs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (exp !== got) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic chk_in(string nm, int lo, int hi, int got);
    comparisons++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // Bounded wait; the count tells how long the state took to come
  task automatic wait_st(ett_state_t s, int lim, output int k);
    k = 0;
    while (st !== s && k < lim) begin
      step(1);
      k++;
    end
  endtask
  task automatic shot(int g, int p, int w);
    int k;
    fire = 1;
    wait_st(ETT_PRE_WAIT, 400, k);
    chk_in("request to grant", (3 + g) * T, (4 + g) * T + 4, k);
    chk("exposure grant", 1, grant);
    wait_st(ETT_INTEGRATE, 400, k);
    chk_in("pre wait", p > 0 ? (p - 1) * T : 0, p * T + 2, k);
    chk("integrating", 1, integ);
    wait_st(ETT_RELEASE, 2200, k);
    chk_in("window", (w - 1) * T, w * T + 2, k);
    chk("frame done", 1, done);
    chk("grant after window", 0, grant);
    step(1);
    chk("frame done pulse", 0, done);
    fire = 0;
    wait_st(ETT_IDLE, 100, k);
    chk_in("release filter", 3 * T, 4 * T + 4, k);
  endtask

  initial begin
    step(12);
    rst = 0;
    chk("grant in reset", 0, grant);
    chk("state in reset", ETT_IDLE, st);
    $display("Test reset done");
    shot(1, 0, 500);
    pre = 16'h0005;
    gdl = 16'h0003;
    win = 16'h0014;
    shot(3, 5, 20);
    fire = 1;
    step(3 * T - 1);
    fire = 0;
    step(6 * T);
    chk("noise pulse", ETT_IDLE, st);
    $display("Test wired done");
    mode = ETT_MODE_AUTO;
    sf = 8'h05;
    fire = 1;
    sense = 1;
    step(5 * T - 1);
    sense = 0;
    step(8 * T);
    chk("short sense", ETT_IDLE, st);
    fire = 0;
    step(4 * T);
    sense = 1;
    wait_st(ETT_INTEGRATE, 200, n);
    chk_in("sensor filter", 5 * T, 6 * T + 4, n);
    chk("no grant in auto", 0, grant);
    sense = 0;
    wait_st(ETT_IDLE, 400, n);
    chk("auto back idle", ETT_IDLE, st);
    $display("Test auto done");
    for (int i = 0; i < 8; i++) begin
      gsel = 3'(i);
      step(2);
      chk("gain active", i > 5 ? 5 : i, gact);
      chk("gain invalid", i > 5, ginv);
    end
    ce = 0;
    gsel = 3'h2;
    step(4);
    chk("gain frozen", 5, gact);
    ce = 1;
    step(2);
    chk("gain after enable", 2, gact);
    $display("Test gain done");
    summarize();
  end
endmodule
